/* File: inc/pwr_pkg.sv */
// constants and types of the power mode and wake controller
package pwr_pkg;
  // --------------------------------------------------
  // register offsets
  // --------------------------------------------------
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS  = 8'h04;
  localparam logic [7:0] MASK_OFS  = 8'h08;
  localparam logic [7:0] TOUT_OFS  = 8'h0C;
  localparam logic [7:0] PPD_OFS   = 8'h10;
  localparam logic [7:0] MACL_OFS  = 8'h14;
  localparam logic [7:0] MACH_OFS  = 8'h18;
  localparam logic [7:0] STRAP_OFS = 8'h1C;
  // --------------------------------------------------
  // fields and codes
  // --------------------------------------------------
  localparam int         MODE_LSB    = 3;
  localparam int         PME_EN_BIT  = 0;
  localparam int         INT_EN_BIT  = 1;
  localparam int         NPORT       = 7;
  localparam int         NEV         = 3;
  localparam int         EV_ENERGY   = 0;
  localparam int         EV_LINK     = 1;
  localparam int         EV_WAKE     = 2;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ENERGY_DETECT_POWER_DOWN   = 2'h1;
  localparam logic [1:0] MODE_SOFT   = 2'h2;
  localparam logic [1:0] MODE_BAD    = 2'h3;
  localparam logic [7:0] SYNC_BYTE   = 8'hFF;
  localparam logic [2:0] SYNC_LEN    = 3'h6;
  localparam logic [2:0] LAST_POS    = 3'h5;
  localparam logic [3:0] LAST_REP    = 4'hF;
  // --------------------------------------------------
  // reset values
  // --------------------------------------------------
  localparam logic [NEV-1:0]   MASK_RST  = 3'h0;
  localparam logic [31:0]      TOUT_RST  = 32'h0000_03E8;
  localparam logic [NPORT-1:0] PPD_RST   = 7'h00;
  localparam logic [47:0]      MAC_RST   = 48'h0000_0000_0000;
  // --------------------------------------------------
  // timing
  // --------------------------------------------------
  localparam int         CLK_NS     = 10;
  localparam int         ENERGY_NS  = 100;
  localparam logic [7:0] ENERGY_CYC = 8'((ENERGY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] LP_PERIOD = 12'hFA0;
  // --------------------------------------------------
  // states
  // --------------------------------------------------
  typedef enum logic [1:0] {
    ST_NORMAL_PWR = 2'b01,
    ST_LOW_PWR    = 2'b10
  } energy_detect_power_down_state_type;
endpackage

/* File: src/power_mode_and_wake_control.sv */
// global power mode, energy-detect sequencing and wake events
// How it works
// [RQ1] power-up and mode 00 give normal operation
// [RQ2] mode 01 selects energy-detect saving
// [RQ3] one global mode at once, all ports
// [RQ4] per-port power down independent of mode
// [RQ5] normal: clocks, phys, macs, bus active
// [RQ6] mode writes accepted, new mode taken
// [RQ7] host keeps auto-negotiation on during energy-detect
// [RQ8] no energy past timeout enters low power
// [RQ9] low power keeps only energy detect; the code also keeps the management bus (o_smi_en) enabled
// [RQ10] low power sends sparse link pulses
// [RQ11] energy over 100ns returns to normal
// [RQ12] soft power-down keeps only management bus
// [RQ13] soft exit resets registers, resamples straps
// [RQ14] three wake events: energy, link, frame
// [RQ15] enabled wake drives power-event pin low
// [RQ16] six ff bytes then sixteen addresses
// [RQ17] events may use either interrupt pin
// [RQ18] mode 10 soft power-down, 11 ignored
// [RQ19] timeout is a writable cycle count
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module power_mode_and_wake_control (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [7:0]       i_paddr,
  input  wire logic [31:0]      i_pwdata,
  output logic      [31:0]      o_prdata,
  output logic                  o_pready,
  output logic                  o_pslverr,
  input  wire logic             i_cable_energy,
  input  wire logic             i_link_up,
  input  wire logic [7:0]       i_strap,
  input  wire logic             i_rx_valid,
  input  wire logic             i_rx_sof,
  input  wire logic [7:0]       i_rx_data,
  output logic                  o_pll_en,
  output logic                  o_phy_en,
  output logic                  o_mac_en,
  output logic                  o_rx_detect_en,
  output logic                  o_smi_en,
  output logic                  o_link_pulse,
  output logic [6:0]            o_port_pd,
  output logic                  o_power_event_out_n,
  output logic                  o_interrupt_out_n
);
  // --------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------
  logic [9:0] sync1_r;   // first stage, read by second only
  logic [9:0] sync2_r;   // usable pin levels
  logic [1:0] prev_r;    // edge memory for energy and link
  // synchronisers run through reset so straps are settled when first captured
  always_ff @(posedge i_clk) begin
    sync1_r <= {i_strap, i_link_up, i_cable_energy};
    sync2_r <= sync1_r;
    if (i_rst) begin
      prev_r <= 2'h0;
    end else begin
      prev_r <= sync2_r[1:0];
    end
  end
  logic       energy_s;
  logic       link_s;
  logic [7:0] strap_s;
  assign energy_s = sync2_r[0];
  assign link_s   = sync2_r[1];
  assign strap_s  = sync2_r[9:2];

  // --------------------------------------------------
  // register state
  // --------------------------------------------------
  logic [1:0]  mode_r, mode_nxt;
  logic        pme_en_r, pme_en_nxt;
  logic        int_en_r, int_en_nxt;
  logic [2:0]  stat_r, stat_nxt;
  logic [2:0]  mask_r, mask_nxt;
  logic [31:0] tout_r, tout_nxt;
  logic [6:0]  ppd_r, ppd_nxt;
  logic [47:0] mac_r, mac_nxt;
  logic [7:0]  strap_r, strap_nxt;
  logic        spend_r, spend_nxt;   // strap capture pending
  logic [31:0] rdata_r, rdata_nxt;
  logic        ready_r, ready_nxt;
  logic        err_r, err_nxt;
  logic        wr;                   // write taken this edge
  logic        hit;                  // setup address is mapped
  logic        soft_exit;            // leaving soft power-down
  logic [1:0]  wmode;
  logic [2:0]  ev;                   // wake events this cycle
  logic        magic_hit;

  // decode, read mux and register updates
  always_comb begin
    wr        = i_psel & i_penable & ready_r & i_pwrite;
    wmode     = i_pwdata[pwr_pkg::MODE_LSB +: 2];
    soft_exit = wr && i_paddr == pwr_pkg::CTRL_OFS && mode_r == pwr_pkg::MODE_SOFT
                && wmode != pwr_pkg::MODE_SOFT && wmode != pwr_pkg::MODE_BAD;
    ev        = 3'h0;
    ev[pwr_pkg::EV_ENERGY] = energy_s & ~prev_r[0];                     // [RQ14]
    ev[pwr_pkg::EV_LINK]   = link_s & ~prev_r[1];                       // [RQ14]
    ev[pwr_pkg::EV_WAKE]   = magic_hit;                                 // [RQ14]
    hit       = 1'b1;
    rdata_nxt = 32'h0000_0000;
    case (i_paddr)
      pwr_pkg::CTRL_OFS:  rdata_nxt = {27'h0, mode_r, 1'b0, int_en_r, pme_en_r};
      pwr_pkg::STAT_OFS:  rdata_nxt = {29'h0, stat_r};
      pwr_pkg::MASK_OFS:  rdata_nxt = {29'h0, mask_r};
      pwr_pkg::TOUT_OFS:  rdata_nxt = tout_r;
      pwr_pkg::PPD_OFS:   rdata_nxt = {25'h0, ppd_r};
      pwr_pkg::MACL_OFS:  rdata_nxt = mac_r[31:0];
      pwr_pkg::MACH_OFS:  rdata_nxt = {16'h0, mac_r[47:32]};
      pwr_pkg::STRAP_OFS: rdata_nxt = {24'h0, strap_r};
      default:            hit = 1'b0;
    endcase
    // answer one cycle after setup, error on unmapped address
    ready_nxt  = i_psel & ~i_penable;                                   // [RQ5]
    err_nxt    = i_psel & ~i_penable & ~hit;
    mode_nxt   = mode_r;
    pme_en_nxt = pme_en_r;
    int_en_nxt = int_en_r;
    mask_nxt   = mask_r;
    tout_nxt   = tout_r;
    ppd_nxt    = ppd_r;
    mac_nxt    = mac_r;
    strap_nxt  = spend_r ? strap_s : strap_r;                           // [RQ13]
    spend_nxt  = 1'b0;
    stat_nxt   = stat_r;
    if (wr && i_paddr == pwr_pkg::STAT_OFS) begin
      stat_nxt = stat_r & ~i_pwdata[2:0];
    end
    stat_nxt = stat_nxt | ev;                                           // set beats clear
    if (soft_exit) begin
      // every register but status back to default, status keeps this cycle's events, straps taken next cycle
      mode_nxt   = pwr_pkg::MODE_NORMAL;                                // [RQ13]
      pme_en_nxt = 1'b0;
      int_en_nxt = 1'b0;
      stat_nxt   = ev;
      mask_nxt   = pwr_pkg::MASK_RST;
      tout_nxt   = pwr_pkg::TOUT_RST;
      ppd_nxt    = pwr_pkg::PPD_RST;
      mac_nxt    = pwr_pkg::MAC_RST;
      spend_nxt  = 1'b1;                                                // [RQ13]
    end else if (wr) begin
      case (i_paddr)
        pwr_pkg::CTRL_OFS: begin
          if (wmode != pwr_pkg::MODE_BAD) begin
            mode_nxt = wmode;                                           // [RQ1] [RQ2] [RQ6] [RQ18]
          end
          pme_en_nxt = i_pwdata[pwr_pkg::PME_EN_BIT];
          int_en_nxt = i_pwdata[pwr_pkg::INT_EN_BIT];
        end
        pwr_pkg::MASK_OFS: mask_nxt = i_pwdata[2:0];
        pwr_pkg::TOUT_OFS: tout_nxt = i_pwdata;                         // [RQ19]
        pwr_pkg::PPD_OFS:  ppd_nxt  = i_pwdata[6:0];                    // [RQ4]
        pwr_pkg::MACL_OFS: mac_nxt  = {mac_r[47:32], i_pwdata};
        pwr_pkg::MACH_OFS: mac_nxt  = {i_pwdata[15:0], mac_r[31:0]};
        default: ;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_r   <= pwr_pkg::MODE_NORMAL;                                 // [RQ1]
      pme_en_r <= 1'b0;
      int_en_r <= 1'b0;
      stat_r   <= 3'h0;
      mask_r   <= pwr_pkg::MASK_RST;
      tout_r   <= pwr_pkg::TOUT_RST;
      ppd_r    <= pwr_pkg::PPD_RST;
      mac_r    <= pwr_pkg::MAC_RST;
      strap_r  <= 8'h00;
      spend_r  <= 1'b1;                                                 // straps caught after release
      rdata_r  <= 32'h0000_0000;
      ready_r  <= 1'b0;
      err_r    <= 1'b0;
    end else begin
      mode_r   <= mode_nxt;
      pme_en_r <= pme_en_nxt;
      int_en_r <= int_en_nxt;
      stat_r   <= stat_nxt;
      mask_r   <= mask_nxt;
      tout_r   <= tout_nxt;
      ppd_r    <= ppd_nxt;
      mac_r    <= mac_nxt;
      strap_r  <= strap_nxt;
      spend_r  <= spend_nxt;
      rdata_r  <= rdata_nxt;
      ready_r  <= ready_nxt;
      err_r    <= err_nxt;
    end
  end

  // --------------------------------------------------
  // energy-detect sequencer
  // --------------------------------------------------
  pwr_pkg::energy_detect_power_down_state_type st_r, st_nxt;
  logic [31:0] idle_r, idle_nxt;   // cycles without energy
  logic [7:0]  ecnt_r, ecnt_nxt;   // cycles with energy
  logic [11:0] lp_r, lp_nxt;       // link pulse spacing
  logic        active;
  always_comb begin
    st_nxt   = st_r;
    idle_nxt = 32'h0;
    ecnt_nxt = 8'h0;
    lp_nxt   = 12'h000;
    if (mode_r != pwr_pkg::MODE_ENERGY_DETECT_POWER_DOWN) begin
      st_nxt = pwr_pkg::ST_NORMAL_PWR;
    end else begin
      case (st_r)
        pwr_pkg::ST_NORMAL_PWR: begin
          if (!energy_s) begin
            idle_nxt = idle_r + 32'h1;
            if (idle_r == tout_r) begin
              st_nxt = pwr_pkg::ST_LOW_PWR;                             // [RQ8]
            end
          end
        end
        pwr_pkg::ST_LOW_PWR: begin
          lp_nxt = (lp_r == pwr_pkg::LP_PERIOD) ? 12'h000 : lp_r + 12'h1; // [RQ10]
          if (energy_s) begin
            ecnt_nxt = ecnt_r + 8'h1;
            if (ecnt_r == pwr_pkg::ENERGY_CYC) begin
              st_nxt = pwr_pkg::ST_NORMAL_PWR;                          // [RQ11]
            end
          end
        end
        default: st_nxt = pwr_pkg::ST_NORMAL_PWR;
      endcase
    end
    active = mode_r == pwr_pkg::MODE_NORMAL ||
             (mode_r == pwr_pkg::MODE_ENERGY_DETECT_POWER_DOWN && st_r == pwr_pkg::ST_NORMAL_PWR); // [RQ5] [RQ9]
  end

  // --------------------------------------------------
  // wake frame matcher
  // --------------------------------------------------
  logic [2:0] sync_r, sync_nxt;   // ff bytes seen
  logic [2:0] pos_r, pos_nxt;     // byte within address
  logic [3:0] rep_r, rep_nxt;     // address copies seen
  logic [7:0] exp_byte;
  always_comb begin
    sync_nxt  = i_rx_sof ? 3'h0 : sync_r;
    pos_nxt   = i_rx_sof ? 3'h0 : pos_r;
    rep_nxt   = i_rx_sof ? 4'h0 : rep_r;
    magic_hit = 1'b0;
    case (pos_nxt)
      3'h0:    exp_byte = mac_r[47:40];
      3'h1:    exp_byte = mac_r[39:32];
      3'h2:    exp_byte = mac_r[31:24];
      3'h3:    exp_byte = mac_r[23:16];
      3'h4:    exp_byte = mac_r[15:8];
      default: exp_byte = mac_r[7:0];
    endcase
    if (i_rx_valid) begin
      if (sync_nxt != pwr_pkg::SYNC_LEN) begin
        sync_nxt = (i_rx_data == pwr_pkg::SYNC_BYTE) ? sync_nxt + 3'h1 : 3'h0; // [RQ16]
      end else if (i_rx_data == exp_byte) begin
        if (pos_nxt == pwr_pkg::LAST_POS) begin
          pos_nxt = 3'h0;
          if (rep_nxt == pwr_pkg::LAST_REP) begin
            magic_hit = 1'b1;                                           // [RQ16]
            sync_nxt  = 3'h0;
            rep_nxt   = 4'h0;
          end else begin
            rep_nxt = rep_nxt + 4'h1;
          end
        end else begin
          pos_nxt = pos_nxt + 3'h1;
        end
      end else if (!(i_rx_data == pwr_pkg::SYNC_BYTE && pos_nxt == 3'h0 && rep_nxt == 4'h0)) begin
        // a break restarts the search, an ff may open a new run
        sync_nxt = (i_rx_data == pwr_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
        pos_nxt  = 3'h0;
        rep_nxt  = 4'h0;
      end
    end
  end

  // sequencer, matcher and pin flops
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r                <= pwr_pkg::ST_NORMAL_PWR;
      idle_r              <= 32'h0;
      ecnt_r              <= 8'h0;
      lp_r                <= 12'h000;
      sync_r              <= 3'h0;
      pos_r               <= 3'h0;
      rep_r               <= 4'h0;
      o_pll_en            <= 1'b1;
      o_phy_en            <= 1'b1;
      o_mac_en            <= 1'b1;
      o_rx_detect_en      <= 1'b1;
      o_smi_en            <= 1'b1;
      o_link_pulse        <= 1'b0;
      o_power_event_out_n <= 1'b1;
      o_interrupt_out_n   <= 1'b1;
    end else begin
      st_r                <= st_nxt;
      idle_r              <= idle_nxt;
      ecnt_r              <= ecnt_nxt;
      lp_r                <= lp_nxt;
      sync_r              <= sync_nxt;
      pos_r               <= pos_nxt;
      rep_r               <= rep_nxt;
      o_pll_en            <= active;                                    // [RQ3] [RQ12]
      o_phy_en            <= active;
      o_mac_en            <= active;                                    // [RQ9]
      o_rx_detect_en      <= mode_r != pwr_pkg::MODE_SOFT;              // [RQ9] [RQ12]
      o_smi_en            <= 1'b1;                                      // [RQ12]
      o_link_pulse        <= st_r == pwr_pkg::ST_LOW_PWR && lp_r == pwr_pkg::LP_PERIOD; // [RQ10]
      o_power_event_out_n <= ~(pme_en_r & |(stat_r & mask_r));          // [RQ15] [RQ17]
      o_interrupt_out_n   <= ~(int_en_r & |(stat_r & mask_r));          // [RQ17]
    end
  end
  assign o_prdata  = rdata_r;
  assign o_pready  = ready_r;
  assign o_pslverr = err_r;
  assign o_port_pd = ppd_r;                                             // [RQ4]

  // --------------------------------------------------
  // assertions
  // --------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic wctrl;
  assign wctrl = wr && i_paddr == pwr_pkg::CTRL_OFS && mode_r != pwr_pkg::MODE_SOFT;
  a_mode_ignore_bad: assert property (wctrl && wmode == 2'h3 |=> mode_r == $past(mode_r)) // [RQ18]
    else $error("reserved mode code changed mode");
  a_mode_energy_detect_power_down_sel: assert property (wctrl && wmode == 2'h1 |=> mode_r == 2'h1) // [RQ2]
    else $error("mode 01 not taken");
  a_mode_norm_sel: assert property (wctrl && wmode == 2'h0 |=> mode_r == 2'h0 ##1 o_mac_en) // [RQ1]
    else $error("mode 00 did not restore normal");
  a_mode_one_only: assert property (mode_r != 2'h3 && $onehot(st_r)) // [RQ3]
    else $error("illegal mode or state");
  a_low_entry: assert property (mode_r == 2'h1 && st_r == pwr_pkg::ST_NORMAL_PWR && !energy_s
    && idle_r == tout_r && !wr |=> st_r == pwr_pkg::ST_LOW_PWR ##1 !o_mac_en) // [RQ8]
    else $error("no low-power entry after timeout");
  a_low_exit: assert property (mode_r == 2'h1 && st_r == pwr_pkg::ST_LOW_PWR && !wr && energy_s
    && ecnt_r < 8'd10 |=> st_r == pwr_pkg::ST_LOW_PWR) // [RQ11]
    else $error("left low power before 100ns of energy");
  a_low_wake: assert property (mode_r == 2'h1 && st_r == pwr_pkg::ST_LOW_PWR && !wr && energy_s
    && ecnt_r == 8'd10 |=> st_r == pwr_pkg::ST_NORMAL_PWR) // [RQ11]
    else $error("no wake after 100ns of energy");
  a_soft_gate: assert property (mode_r == 2'h2 |=> !o_pll_en && !o_mac_en && o_smi_en) // [RQ12]
    else $error("soft power-down gating wrong");
  a_soft_exit: assert property (soft_exit |=> mode_r == 2'h0 && mask_r == 3'h0
    ##1 strap_r == $past(strap_s)) // [RQ13]
    else $error("soft exit did not reset and resample");
  a_set_wins: assert property ((|ev) |=> (stat_r & $past(ev)) == $past(ev)) // [RQ14]
    else $error("event lost under clear");
  a_pme_pin: assert property (pme_en_r && |(stat_r & mask_r) |=> !o_power_event_out_n) // [RQ15]
    else $error("power event pin not asserted");
  a_port_pd: assert property (wr && i_paddr == pwr_pkg::PPD_OFS |=> o_port_pd == $past(i_pwdata[6:0])) // [RQ4]
    else $error("port power down not applied");
  c_low_power: cover property (st_r == pwr_pkg::ST_LOW_PWR ##1 st_r == pwr_pkg::ST_NORMAL_PWR);
  c_magic: cover property (magic_hit);
  c_soft_exit: cover property (soft_exit);
  c_pulse: cover property (o_link_pulse);
endmodule
`default_nettype wire

/* File: verif/host_model.sv */
// host model: apb master that reaches the controller registers
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        i_clk,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  input  wire logic [31:0] i_prdata,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata
);
  // ----------------------------------------
  // idle bus and transfer task
  // ----------------------------------------
  // this host never turns auto-negotiation off, so energy-detect stays legal
  initial begin
    o_psel    = 1'h0;
    o_penable = 1'h0;
    o_pwrite  = 1'h0;
    o_paddr   = 8'h00;
    o_pwdata  = 32'h0000_0000;
  end
  // one transfer: setup cycle, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    q = 32'hXXXX_XXXX;
    e = 1'hX;
    @(posedge i_clk);
    o_psel    <= 1'h1;
    o_pwrite  <= w;
    o_paddr   <= a;
    o_pwdata  <= d;
    @(posedge i_clk);
    o_penable <= 1'h1;
    // wait for the slave answer; only the bench timeout ends a dead wait
    do begin
      @(posedge i_clk);
    end while (i_pready !== 1'h1);
    q = i_prdata;
    e = i_pslverr;
    o_psel    <= 1'h0;
    o_penable <= 1'h0;
    // released lines show no stale value
    o_paddr   <= ~a;
    o_pwdata  <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: verif/power_mode_and_wake_control_tb.sv */
// self-checking bench of the power mode and wake controller
`timescale 1ns/1ps
`default_nettype none
module power_mode_and_wake_control_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        i_clk, i_rst, energy, link, rx_valid, rx_sof;
  logic [7:0]  strap, rx_data, paddr;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata;
  logic        pll_en, phy_en, mac_en, rxd_en, smi_en, lpulse, power_event_out_n, int_n;
  logic [6:0]  port_pd;
  int          checks, miscompares, cycles;
  localparam logic [47:0] MAC = 48'hA1B2_C3D4_E5F6;
  // ----------------------------------------
  // clock, instances, timeout
  // ----------------------------------------
  initial i_clk = 1'h0;
  always #5 i_clk = ~i_clk;
  host_model host (.i_clk(i_clk), .i_pready(pready), .i_pslverr(pslverr), .i_prdata(prdata),
    .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
  power_mode_and_wake_control dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_cable_energy(energy),
    .i_link_up(link), .i_strap(strap), .i_rx_valid(rx_valid), .i_rx_sof(rx_sof),
    .i_rx_data(rx_data), .o_pll_en(pll_en), .o_phy_en(phy_en), .o_mac_en(mac_en),
    .o_rx_detect_en(rxd_en), .o_smi_en(smi_en), .o_link_pulse(lpulse), .o_port_pd(port_pd),
    .o_power_event_out_n(power_event_out_n), .o_interrupt_out_n(int_n));
  // a hang counts as a mismatch and ends the run
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      results();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    host.apb(1'h1, a, d, q, e);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    host.apb(1'h0, a, 32'h0000_0000, q, e);
    chk(nm, q, x);
  endtask
  // one frame: header byte, sync run, sixteen address copies, first byte first
  task automatic frame(input logic [47:0] m);
    logic [7:0] b[$];
    b.push_back(8'h00);
    repeat (6) b.push_back(8'hFF);
    for (int i = 0; i < 96; i++) begin
      b.push_back(m[47-8*(i%6) -: 8]);
    end
    foreach (b[i]) begin
      @(posedge i_clk);
      rx_valid <= 1'h1;
      rx_sof   <= (i == 0);
      rx_data  <= b[i];
    end
    @(posedge i_clk);
    rx_valid <= 1'h0;
    rx_sof   <= 1'h0;
    rx_data  <= ~b[b.size()-1];
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    chk("enables", {pll_en, phy_en, mac_en, rxd_en, smi_en}, 32'h1F);
    chk("pins", {power_event_out_n, int_n}, 32'h3);
    rd("ctrl", pwr_pkg::CTRL_OFS, 32'h0);
    rd("tout", pwr_pkg::TOUT_OFS, pwr_pkg::TOUT_RST);
    rd("strap", pwr_pkg::STRAP_OFS, 32'hA5);
    host.apb(1'h0, 8'h20, 32'h0, q, e);
    chk("unmapped err", e, 32'h1);
    chk("unmapped data", q, 32'h0);
    $display("done reset");
  endtask
  task automatic t_energy_detect_power_down();
    int n;
    n = 0;
    wr(pwr_pkg::PPD_OFS, 32'h55);
    wr(pwr_pkg::TOUT_OFS, 32'd20);
    wr(pwr_pkg::CTRL_OFS, 32'h08);
    cyc(30);
    chk("lowpwr en", {pll_en, phy_en, mac_en, rxd_en, smi_en}, 32'h3);
    chk("port pd", port_pd, 32'h55);
    repeat (4001) begin
      @(posedge i_clk);
      if (lpulse === 1'h1) n++;
    end
    chk("link pulses", n, 32'd1);
    // 80 ns of energy is too short to wake
    @(posedge i_clk);
    energy <= 1'h1;
    cyc(8);
    energy <= 1'h0;
    cyc(20);
    chk("short burst", pll_en, 32'h0);
    energy <= 1'h1;
    cyc(20);
    chk("woken en", {pll_en, phy_en, mac_en, rxd_en}, 32'hF);
    rd("stat energy", pwr_pkg::STAT_OFS, 32'h1);
    wr(pwr_pkg::STAT_OFS, 32'h7);
    wr(pwr_pkg::CTRL_OFS, 32'h00);
    energy <= 1'h0;
    cyc(40);
    chk("normal stays", {pll_en, phy_en, mac_en}, 32'h7);
    $display("done energy detect");
  endtask
  task automatic t_wake();
    wr(pwr_pkg::MASK_OFS, 32'h7);
    wr(pwr_pkg::MACL_OFS, MAC[31:0]);
    wr(pwr_pkg::MACH_OFS, {16'h0, MAC[47:32]});
    wr(pwr_pkg::CTRL_OFS, 32'h03);
    frame(MAC ^ 48'h1);
    rd("stat foreign", pwr_pkg::STAT_OFS, 32'h0);
    frame(MAC);
    cyc(3);
    rd("stat frame", pwr_pkg::STAT_OFS, 32'h4);
    chk("pins set", {power_event_out_n, int_n}, 32'h0);
    wr(pwr_pkg::MASK_OFS, 32'h3);
    cyc(2);
    chk("pins masked", {power_event_out_n, int_n}, 32'h3);
    wr(pwr_pkg::STAT_OFS, 32'h4);
    wr(pwr_pkg::CTRL_OFS, 32'h01);
    @(posedge i_clk);
    link <= 1'h1;
    cyc(6);
    rd("stat link", pwr_pkg::STAT_OFS, 32'h2);
    chk("pme only", {power_event_out_n, int_n}, 32'h1);
    wr(pwr_pkg::STAT_OFS, 32'h2);
    cyc(2);
    chk("pins clear", {power_event_out_n, int_n}, 32'h3);
    $display("done wake");
  endtask
  task automatic t_soft();
    wr(pwr_pkg::CTRL_OFS, 32'h1B);
    rd("mode ignored", pwr_pkg::CTRL_OFS, 32'h03);
    wr(pwr_pkg::PPD_OFS, 32'h7F);
    wr(pwr_pkg::CTRL_OFS, 32'h10);
    cyc(3);
    chk("soft en", {pll_en, phy_en, mac_en, rxd_en, smi_en}, 32'h1);
    chk("soft one mode", port_pd, 32'h7F);
    strap <= 8'h5A;
    cyc(5);
    wr(pwr_pkg::CTRL_OFS, 32'h00);
    cyc(4);
    rd("tout dflt", pwr_pkg::TOUT_OFS, pwr_pkg::TOUT_RST);
    rd("ppd dflt", pwr_pkg::PPD_OFS, 32'h0);
    rd("mask dflt", pwr_pkg::MASK_OFS, 32'h0);
    rd("strap new", pwr_pkg::STRAP_OFS, 32'h5A);
    chk("exit en", {pll_en, phy_en, mac_en, rxd_en, port_pd}, 32'h780);
    $display("done soft power down");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_rst       = 1'h1;
    energy      = 1'h0;
    link        = 1'h0;
    strap       = 8'hA5;
    rx_valid    = 1'h0;
    rx_sof      = 1'h0;
    rx_data     = 8'h00;
    checks      = 0;
    miscompares = 0;
    cycles      = 0;
    cyc(8);
    i_rst <= 1'h0;
    cyc(2);
    t_reset();
    t_energy_detect_power_down();
    t_wake();
    t_soft();
    results();
  end
endmodule
`default_nettype wire
